// file: hdl/pmsl_power_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - main input low selects backup battery
// - main input present and above 5.4 V selects 3.1 V regulator
// - backup loss without main resets rtc registers
// - comparator results shown as status bits
// - status interrupt only when mask allows
// - temp comparator and source on, separately switchable
// - standby low enters low power, high exits
// - scaling or decay only where rail programmed
// - io rail uses decay bit only
// - memory core follows enable, termination follows pin
// - three-level strap picks memory core voltage
// - termination pin also scales memory core
// - rtc ldo from 5 V above 5.4 V
// - off state refuses all enables
// - off keeps only power-path comparators
// - main input present enters startup
// - otp load only after both supplies good
// - rtc regulator on after 5 V good
// - ready after otp load and rtc regulation
// - ready accepts rail enables, blocks available
// - standby entry on falling edge with power good
module pmsl_power_ctrl
    import pmsl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // analog comparator results
    input wire pmsl_analog_t analogIn,
    // pins from host and embedded controller
    input wire logic standbyPin,
    input wire logic allSystemPowerGood,
    input wire logic memoryCoreEnablePin,
    input wire logic terminationControlPin,
    input wire logic [1:0] memoryTypeStrap,
    input wire logic [RAIL_COUNT-1:0] railEnableReq,
    // configuration bits written by software
    input wire pmsl_pp_t irqMask,
    input wire logic tempComparatorEnable,
    input wire logic tempCurrentSourceEnable,
    input wire logic [RAIL_COUNT*RC_WIDTH-1:0] railCtrlWrite,
    input wire logic [RAIL_COUNT-1:0] railCtrlWe,
    // state and status
    output pmsl_state_t powerState,
    output logic otpLoadBusy,
    output logic otpLoadDone,
    output pmsl_pp_t powerPathStatus,
    output logic ecIrq,
    output logic ppOpenDrainOe,
    // rtc domain
    output pmsl_rtc_t rtcCtrl,
    // board temperature monitor
    output logic tempComparatorOn,
    output logic tempCurrentSourceOn,
    // rails
    output logic lowPowerMode,
    output logic standbyState,
    output logic [RAIL_COUNT-1:0] railEnable,
    output logic [RAIL_COUNT-1:0] railDvs,
    output logic [RAIL_COUNT-1:0] railDecay,
    output logic [RAIL_COUNT*RC_WIDTH-1:0] railCtrlRead,
    output logic memoryCoreOn,
    output logic memoryTermOn,
    output pmsl_memv_t memoryCoreTarget,
    output logic internalSupplyOn
);
    typedef struct packed {
        pmsl_state_t state;
        logic [7:0] otpCnt;
        logic otpDone;
        logic strapTaken;
        pmsl_memv_t memv;
        logic standbyPrev;
        logic lowPower;
        logic standby;
        pmsl_pp_t ppFlags;
        logic irq;
        pmsl_rtc_t rtc;
        logic [RAIL_COUNT*RC_WIDTH-1:0] railCtrl;
        logic [RAIL_COUNT-1:0] railEn;
        logic [RAIL_COUNT-1:0] dvs;
        logic [RAIL_COUNT-1:0] decay;
        logic memCore;
        logic memTerm;
        logic tempCmp;
        logic tempSrc;
    } pmsl_regs_t;

    pmsl_regs_t state_ff;
    pmsl_regs_t nxt_state;
    logic [RAIL_COUNT-1:0] dvsCalc;
    logic [RAIL_COUNT-1:0] decayCalc;

    // strap decode; floating pad selects the low-voltage part
    function automatic pmsl_memv_t strap_decode(input logic [1:0] s);
        case (s)
            STRAP_LOW: strap_decode = MEM_1V2;
            STRAP_HIGH: strap_decode = MEM_1V35;
            STRAP_FLOAT: strap_decode = MEM_1V1;
            default: strap_decode = MEM_1V1;
        endcase
    endfunction : strap_decode

    // otp default image for rail control; all zero means no lpm action
    function automatic logic [RAIL_COUNT*RC_WIDTH-1:0] otp_image();
        otp_image = '0;
    endfunction : otp_image

    pmsl_lpm_rails u_lpm (
        .railCtrl(state_ff.railCtrl),
        .lowPower(state_ff.lowPower),
        .termLow(!terminationControlPin && state_ff.state == ST_READY),
        .dvsActive(dvsCalc),
        .decayActive(decayCalc)
    );

    // next-state logic for the whole block
    always_comb begin
        logic ready;
        logic mainOk;
        logic fall;
        ready = 1'b0;
        mainOk = analogIn.mainAboveUvlo;
        fall = 1'b0;
        nxt_state = state_ff;
        ready = (state_ff.state == ST_READY);

        // power state sequence
        case (state_ff.state)
            ST_OFF, ST_BACKUP: begin
                if (mainOk) begin
                    nxt_state.state = ST_STARTUP;
                end else if (analogIn.backupAboveUvlo) begin
                    nxt_state.state = ST_BACKUP;
                end else begin
                    nxt_state.state = ST_OFF;
                end
            end
            ST_STARTUP: begin
                // both internal supplies must be good before otp load
                if (analogIn.ldo3v3Good && analogIn.ldo5vGood) begin
                    nxt_state.state = ST_LOAD;
                    nxt_state.otpCnt = OTP_LOAD_CYC;
                end
            end
            ST_LOAD: begin
                if (state_ff.otpCnt != 8'h00) begin
                    nxt_state.otpCnt = state_ff.otpCnt - 8'h01;
                end else if (!state_ff.otpDone) begin
                    nxt_state.otpDone = 1'b1;
                    nxt_state.railCtrl = otp_image();
                end else if (state_ff.rtc.rtcLdoOn &&
                             analogIn.rtcRegInReg) begin
                    nxt_state.state = ST_READY;
                end
            end
            ST_READY: begin
                nxt_state.state = ST_READY;
            end
            default: nxt_state.state = ST_OFF;
        endcase
        // loss of main input wins over any sequence step
        if (!mainOk && (state_ff.state == ST_STARTUP ||
                        state_ff.state == ST_LOAD ||
                        state_ff.state == ST_READY)) begin
            nxt_state.state = analogIn.backupAboveUvlo ?
                ST_BACKUP : ST_OFF;
            nxt_state.otpDone = 1'b0;
            nxt_state.otpCnt = 8'h00;
        end

        // rtc source selection follows main input level directly
        nxt_state.rtc.selBackup = !mainOk ||
            !analogIn.mainBattAbove5v4;
        nxt_state.rtc.selLdo = mainOk &&
            analogIn.mainBattAbove5v4;
        nxt_state.rtc.rtcLdoOn = mainOk && analogIn.ldo5vGood;
        nxt_state.rtc.rtcLdoFrom5v = nxt_state.rtc.rtcLdoOn &&
            analogIn.mainBattAbove5v4;
        nxt_state.rtc.rtcDomainReset = !mainOk &&
            !analogIn.backupAboveUvlo;

        // power-path comparators work in every state
        nxt_state.ppFlags.adapter = analogIn.adapterIn;
        nxt_state.ppFlags.battOne = analogIn.battOneLowIn;
        nxt_state.ppFlags.battTwo = analogIn.battTwoLowIn;
        nxt_state.irq = |(nxt_state.ppFlags & irqMask);

        // rail control writes taken only in ready; lost while unpowered
        for (int i = 0; i < RAIL_COUNT; i++) begin
            if (railCtrlWe[i] && ready) begin
                nxt_state.railCtrl[i*RC_WIDTH +: RC_WIDTH] =
                    railCtrlWrite[i*RC_WIDTH +: RC_WIDTH];
            end
        end
        if (!mainOk) begin
            nxt_state.railCtrl = otp_image();
        end

        // temperature monitor enables, honoured only in ready
        nxt_state.tempCmp = ready && tempComparatorEnable;
        nxt_state.tempSrc = ready && tempCurrentSourceEnable;

        // standby pin: falling edge with power good enters standby
        fall = state_ff.standbyPrev && !standbyPin;
        nxt_state.standbyPrev = standbyPin;
        if (!ready || standbyPin) begin
            nxt_state.standby = 1'b0;
        end else if (fall && allSystemPowerGood) begin
            nxt_state.standby = 1'b1;
        end
        nxt_state.lowPower = ready && !standbyPin;

        // strap sampled once on each entry to ready
        if (!ready) begin
            nxt_state.strapTaken = 1'b0;
        end else if (!state_ff.strapTaken) begin
            nxt_state.strapTaken = 1'b1;
            nxt_state.memv = strap_decode(memoryTypeStrap);
        end

        // enables only honoured in ready
        nxt_state.railEn = ready ? railEnableReq : '0;
        nxt_state.memCore = ready && memoryCoreEnablePin;
        nxt_state.memTerm = ready && terminationControlPin;
        nxt_state.dvs = ready ? dvsCalc : '0;
        nxt_state.decay = ready ? decayCalc : '0;
    end

    // single state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '0;
            state_ff.rtc.selBackup <= 1'b1;
            state_ff.memv <= MEM_1V2;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state record
    assign powerState = state_ff.state;
    assign otpLoadBusy = (state_ff.state == ST_LOAD) && !state_ff.otpDone;
    assign otpLoadDone = state_ff.otpDone;
    assign powerPathStatus = state_ff.ppFlags;
    assign ecIrq = state_ff.irq;
    // open-drain status pin pulls low when the adapter flag is clear
    assign ppOpenDrainOe = !state_ff.ppFlags.adapter;
    assign rtcCtrl = state_ff.rtc;
    assign tempComparatorOn = state_ff.tempCmp;
    assign tempCurrentSourceOn = state_ff.tempSrc;
    assign lowPowerMode = state_ff.lowPower;
    assign standbyState = state_ff.standby;
    assign railEnable = state_ff.railEn;
    assign railDvs = state_ff.dvs;
    assign railDecay = state_ff.decay;
    assign railCtrlRead = state_ff.railCtrl;
    assign memoryCoreOn = state_ff.memCore;
    assign memoryTermOn = state_ff.memTerm;
    assign memoryCoreTarget = state_ff.memv;
    assign internalSupplyOn = state_ff.state != ST_OFF &&
                              state_ff.state != ST_BACKUP;

    // guards; the mask is an input, so the interrupt sees last cycle's copy
    a_off_no_rails: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state != ST_READY |=> railEnable == '0)
        else $error("rail enabled outside ready");
    a_off_no_temp: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state != ST_READY
        |=> !tempComparatorOn && !tempCurrentSourceOn)
        else $error("temperature monitor on outside ready");
    a_irq_masked: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        ecIrq |-> |(powerPathStatus & $past(irqMask)))
        else $error("interrupt without unmasked flag");
    a_irq_raised: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        |(powerPathStatus & $past(irqMask)) |-> ecIrq)
        else $error("unmasked flag without interrupt");
    a_rtc_backup: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !analogIn.mainAboveUvlo |=> rtcCtrl.selBackup)
        else $error("backup not selected");
    a_rtc_ldo_sel: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        analogIn.mainAboveUvlo && analogIn.mainBattAbove5v4
        |=> rtcCtrl.selLdo && !rtcCtrl.selBackup)
        else $error("ldo not selected");
    a_rtc_reset: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !analogIn.mainAboveUvlo && !analogIn.backupAboveUvlo
        |=> rtcCtrl.rtcDomainReset)
        else $error("rtc reset missing");
    a_rtc_ldo_on: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        analogIn.mainAboveUvlo && analogIn.ldo5vGood
        |=> rtcCtrl.rtcLdoOn)
        else $error("rtc regulator not switched on");
    a_status_mirror: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> powerPathStatus.battOne == $past(analogIn.battOneLowIn))
        else $error("status bit mismatch");
    a_startup_entry: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state inside {ST_OFF, ST_BACKUP} && analogIn.mainAboveUvlo
        |=> state_ff.state == ST_STARTUP)
        else $error("startup not entered");
    a_load_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state == ST_STARTUP
        && !(analogIn.ldo3v3Good && analogIn.ldo5vGood)
        |=> state_ff.state != ST_LOAD)
        else $error("otp load before supplies good");
    a_otp_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(otpLoadDone) |-> $past(state_ff.state == ST_LOAD, 1))
        else $error("otp load outside load phase");
    a_ready_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $changed(state_ff.state) && state_ff.state == ST_READY
        |-> $past(otpLoadDone && rtcCtrl.rtcLdoOn && analogIn.rtcRegInReg))
        else $error("ready too early");
    a_uvlo_exit: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state == ST_READY && !analogIn.mainAboveUvlo
        |=> state_ff.state inside {ST_OFF, ST_BACKUP})
        else $error("ready kept without main input");
    a_lpm_level: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state == ST_READY && !standbyPin |=> lowPowerMode)
        else $error("low power not entered");
    a_lpm_exit: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        standbyPin |=> !lowPowerMode)
        else $error("low power kept while awake");
    a_standby_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        $rose(standbyState) |-> $past(allSystemPowerGood))
        else $error("standby without power good");
    a_mem_follow: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        state_ff.state == ST_READY
        |=> memoryCoreOn == $past(memoryCoreEnablePin))
        else $error("memory core enable not followed");
    a_io_no_dvs: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        railDvs[IO_RAIL_IDX] == 1'b0)
        else $error("io rail scaled");
endmodule : pmsl_power_ctrl

// file: hdl/pmsl_pkg.sv
package pmsl_pkg;
    // top-level power states
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_BACKUP = 3'b001,
        ST_STARTUP = 3'b010,
        ST_LOAD = 3'b011,
        ST_READY = 3'b100
    } pmsl_state_t;

    // memory core target selection from the three-level strap
    typedef enum logic [1:0] {
        MEM_1V2 = 2'h0,
        MEM_1V35 = 2'h1,
        MEM_1V1 = 2'h2
    } pmsl_memv_t;

    // strap levels as sensed by the pad
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_HIGH = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;

    // number of rail control registers 0x30..0x38
    localparam int RAIL_COUNT = 9;
    localparam logic [7:0] RAIL_BASE_ADDR = 8'h30;
    localparam logic [7:0] RAIL_LAST_ADDR = 8'h38;
    localparam logic [7:0] MEMCORE_CTRL_ADDR = 8'h36;
    // io rail register index and memory core index within the rail set
    localparam logic [3:0] IO_RAIL_IDX = 4'h8;
    localparam logic [3:0] MEMCORE_IDX = 4'h6;

    // rail control register field positions
    localparam int RC_DVS_BIT = 0;
    localparam int RC_DECAY_BIT = 1;
    localparam int RC_WIDTH = 8;

    // otp load duration
    localparam int OTP_LOAD_NS = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] OTP_LOAD_CYC =
        8'((OTP_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // analog comparator results
    typedef struct packed {
        logic mainAboveUvlo;
        logic backupAboveUvlo;
        logic mainBattAbove5v4;
        logic ldo3v3Good;
        logic ldo5vGood;
        logic rtcRegInReg;
        logic adapterIn;
        logic battOneLowIn;
        logic battTwoLowIn;
    } pmsl_analog_t;

    // power-path flags and masks
    typedef struct packed {
        logic adapter;
        logic battOne;
        logic battTwo;
    } pmsl_pp_t;

    // rtc rail source selection
    typedef struct packed {
        logic selBackup;
        logic selLdo;
        logic rtcLdoOn;
        logic rtcLdoFrom5v;
        logic rtcDomainReset;
    } pmsl_rtc_t;
endpackage : pmsl_pkg

// file: hdl/pmsl_lpm_rails.sv
`timescale 1ns/1ps
// per-rail low-power action decode
module pmsl_lpm_rails
    import pmsl_pkg::*;
(
    // rail control image
    input wire logic [RAIL_COUNT*RC_WIDTH-1:0] railCtrl,
    // mode
    input wire logic lowPower,
    input wire logic termLow,
    // per-rail actions
    output logic [RAIL_COUNT-1:0] dvsActive,
    output logic [RAIL_COUNT-1:0] decayActive
);
    // io rail honours only decay bit; memory core follows termination pin
    always_comb begin
        for (int i = 0; i < RAIL_COUNT; i++) begin
            if (4'(i) == IO_RAIL_IDX) begin
                dvsActive[i] = 1'b0;
                decayActive[i] = lowPower &&
                    railCtrl[i*RC_WIDTH+RC_DECAY_BIT];
            end else if (4'(i) == MEMCORE_IDX) begin
                dvsActive[i] = termLow &&
                    railCtrl[i*RC_WIDTH+RC_DVS_BIT];
                decayActive[i] = 1'b0;
            end else begin
                dvsActive[i] = lowPower &&
                    railCtrl[i*RC_WIDTH+RC_DVS_BIT];
                decayActive[i] = lowPower &&
                    railCtrl[i*RC_WIDTH+RC_DECAY_BIT];
            end
        end
    end
endmodule : pmsl_lpm_rails

// file: verification/pmsl_host_model.sv
`timescale 1ns/1ps
// host and embedded controller side: sleep pins and rail register writes
module pmsl_host_model
    import pmsl_pkg::*;
(
    // clock
    input wire logic core_clk,
    // sleep and memory pins
    output logic standbyPin,
    output logic allSystemPowerGood,
    output logic terminationControlPin,
    output logic memoryCoreEnablePin,
    // rail register writes
    output logic [RAIL_COUNT*RC_WIDTH-1:0] railCtrlWrite,
    output logic [RAIL_COUNT-1:0] railCtrlWe
);
    // idle: host awake, no write pending
    initial begin
        standbyPin = 1'b1;
        allSystemPowerGood = 1'b0;
        terminationControlPin = 1'b1;
        memoryCoreEnablePin = 1'b0;
        railCtrlWrite = '0;
        railCtrlWe = '0;
    end

    // pin levels move just after an edge
    task automatic set_pins(input logic sb, pg, term, mem);
        @(posedge core_clk);
        standbyPin <= sb;
        allSystemPowerGood <= pg;
        terminationControlPin <= term;
        memoryCoreEnablePin <= mem;
    endtask : set_pins

    // writes go out in any mode; data is scrambled once the strobe drops
    task automatic write_rails(input logic [RAIL_COUNT*RC_WIDTH-1:0] d,
                               input logic [RAIL_COUNT-1:0] we);
        @(posedge core_clk);
        railCtrlWrite <= d;
        railCtrlWe <= we;
        @(posedge core_clk);
        railCtrlWe <= '0;
        railCtrlWrite <= ~d; // stale data must not be relied on
    endtask : write_rails
endmodule : pmsl_host_model

// file: verification/pmsl_power_ctrl_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the power-state and low-power control
module pmsl_power_ctrl_tb_top
    import pmsl_pkg::*;
;
`define CHK(g, e) if ((g) !== (e)) begin \
    $display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); \
    err_total++; end n_checks++;
    logic core_clk, arst_n, tcEn, tsEn, sbPin, pgPin, termPin, memPin;
    logic busy, done, irq, odOe, tcOn, tsOn, lpm, sbySt, memOn, termOn, supOn;
    pmsl_analog_t ana;
    pmsl_state_t st;
    pmsl_pp_t mask, pps;
    pmsl_rtc_t rtc;
    pmsl_memv_t memTgt;
    logic [1:0] strap;
    logic [RAIL_COUNT-1:0] enReq, we, rEn, rDvs, rDec;
    logic [RAIL_COUNT*RC_WIDTH-1:0] wData, rRd;
    int err_total = 0;
    int n_checks = 0;

    pmsl_host_model host (.core_clk(core_clk), .standbyPin(sbPin),
        .allSystemPowerGood(pgPin), .terminationControlPin(termPin),
        .memoryCoreEnablePin(memPin), .railCtrlWrite(wData),
        .railCtrlWe(we));

    pmsl_power_ctrl dut (.core_clk(core_clk), .arst_n(arst_n),
        .analogIn(ana), .standbyPin(sbPin), .allSystemPowerGood(pgPin),
        .memoryCoreEnablePin(memPin), .terminationControlPin(termPin),
        .memoryTypeStrap(strap), .railEnableReq(enReq), .irqMask(mask),
        .tempComparatorEnable(tcEn), .tempCurrentSourceEnable(tsEn),
        .railCtrlWrite(wData), .railCtrlWe(we), .powerState(st),
        .otpLoadBusy(busy), .otpLoadDone(done), .powerPathStatus(pps),
        .ecIrq(irq), .ppOpenDrainOe(odOe), .rtcCtrl(rtc),
        .tempComparatorOn(tcOn), .tempCurrentSourceOn(tsOn),
        .lowPowerMode(lpm), .standbyState(sbySt), .railEnable(rEn),
        .railDvs(rDvs), .railDecay(rDec), .railCtrlRead(rRd),
        .memoryCoreOn(memOn), .memoryTermOn(termOn),
        .memoryCoreTarget(memTgt), .internalSupplyOn(supOn));

    // expected scaling: io rail never scales, memory core follows the termination pin
    function automatic logic [RAIL_COUNT-1:0] exp_dvs(
        input logic [RAIL_COUNT*RC_WIDTH-1:0] c, input logic lp, term);
        logic [RAIL_COUNT-1:0] r;
        for (int i = 0; i < RAIL_COUNT; i++) r[i] = lp & c[i*RC_WIDTH];
        r[MEMCORE_IDX] = ~term & c[MEMCORE_IDX*RC_WIDTH+RC_DVS_BIT];
        r[IO_RAIL_IDX] = 1'b0;
        return r;
    endfunction : exp_dvs

    // expected decay from the decay bit of each rail
    function automatic logic [RAIL_COUNT-1:0] exp_dec(
        input logic [RAIL_COUNT*RC_WIDTH-1:0] c, input logic lp);
        logic [RAIL_COUNT-1:0] r;
        for (int i = 0; i < RAIL_COUNT; i++) begin
            r[i] = lp & c[i*RC_WIDTH+RC_DECAY_BIT];
        end
        return r;
    endfunction : exp_dec

    task automatic wrap_up();
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    // wait n sampling edges, then settle 1 ns past the last one
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wait_state(input pmsl_state_t s, input int bound);
        for (int k = 0; k < bound && st !== s; k++) tick(1);
        `CHK(st, s)
        if (st !== s) wrap_up();
    endtask : wait_state

    // full start-up walk, strap set beforehand so it is taken at ready
    task automatic power_up(input logic [1:0] s);
        int k;
        @(posedge core_clk);
        strap <= s;
        ana.mainAboveUvlo <= 1'b1;
        ana.ldo5vGood <= 1'b1;
        ana.mainBattAbove5v4 <= 1'b1;
        tick(1);
        `CHK(st, ST_STARTUP)
        `CHK(supOn, 1'b1)
        tick(4);
        `CHK(st, ST_STARTUP)
        `CHK(rtc.rtcLdoOn, 1'b1)
        @(posedge core_clk);
        ana.ldo3v3Good <= 1'b1;
        tick(1);
        `CHK(st, ST_LOAD)
        `CHK(busy, 1'b1)
        k = 0;
        while (done !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        `CHK(k >= OTP_LOAD_CYC - 1 && k <= OTP_LOAD_CYC + 2, 1'b1)
        `CHK(busy, 1'b0)
        tick(4);
        `CHK(st === ST_READY, 1'b0)
        @(posedge core_clk);
        ana.rtcRegInReg <= 1'b1;
        wait_state(ST_READY, 4);
        tick(1);
        `CHK(memTgt, pmsl_memv_t'(s))
        `CHK({rtc.selLdo, rtc.selBackup}, 2'h2)
    endtask : power_up

    // main loss, then backup loss
    task automatic power_down();
        @(posedge core_clk);
        ana.mainAboveUvlo <= 1'b0;
        ana.ldo3v3Good <= 1'b0;
        ana.ldo5vGood <= 1'b0;
        ana.rtcRegInReg <= 1'b0;
        tick(1);
        `CHK(st, ST_BACKUP)
        tick(1);
        `CHK(rtc.selBackup, 1'b1)
        `CHK(rEn, '0)
        @(posedge core_clk);
        ana.backupAboveUvlo <= 1'b0;
        tick(1);
        `CHK(st, ST_OFF)
        `CHK(supOn, 1'b0)
        `CHK(rtc.rtcDomainReset, 1'b1)
        @(posedge core_clk);
        ana.backupAboveUvlo <= 1'b1;
        tick(2);
    endtask : power_down

    // random traffic in ready, first pass all flags up with masks closed
    task automatic ready_tests();
        logic [2:0] f;
        logic [RAIL_COUNT*RC_WIDTH-1:0] img;
        for (int i = 0; i < 30; i++) begin
            f = (i == 0) ? 3'h7 : 3'($urandom);
            @(posedge core_clk);
            enReq <= RAIL_COUNT'($urandom);
            mask <= (i == 0) ? pmsl_pp_t'(3'h0) : pmsl_pp_t'(3'($urandom));
            {ana.adapterIn, ana.battOneLowIn, ana.battTwoLowIn} <= f;
            ana.mainBattAbove5v4 <= 1'($urandom);
            tcEn <= 1'($urandom);
            tsEn <= 1'($urandom);
            host.set_pins(1'b1, 1'b0, 1'($urandom), 1'($urandom));
            tick(3);
            `CHK(rEn, enReq)
            `CHK(pps, pmsl_pp_t'(f))
            `CHK(irq, |(f & mask))
            `CHK({tcOn, tsOn}, {tcEn, tsEn})
            `CHK({memOn, termOn}, {memPin, termPin})
            `CHK(rtc.rtcLdoFrom5v, ana.mainBattAbove5v4)
        end
        // standby entry needs power good at the falling edge
        host.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
        tick(2);
        `CHK(sbySt, 1'b0)
        host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        host.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
        tick(2);
        `CHK(sbySt, 1'b1)
        // rewrites in both modes, all standby and termination pin combinations
        for (int i = 0; i < 8; i++) begin
            img = (RAIL_COUNT*RC_WIDTH)'({$urandom, $urandom, $urandom});
            host.write_rails(img, '1);
            host.set_pins(~i[0], 1'b1, i[1], 1'b1);
            tick(3);
            `CHK(rRd, img)
            `CHK(lpm, i[0])
            `CHK(rDvs, exp_dvs(img, i[0], i[1]))
            `CHK(rDec & 9'h1bf, exp_dec(img, i[0]) & 9'h1bf)
        end
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
    endtask : ready_tests

    // free-running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        $display("mismatch t=%0t got %0h exp %0h", $time, 1'b0, 1'b1);
        err_total++;
        wrap_up();
    end

    // main sequence
    initial begin
        void'($urandom(77702));
        ana = '0;
        ana.backupAboveUvlo = 1'b1;
        ana.mainBattAbove5v4 = 1'b1;
        strap = STRAP_LOW;
        enReq = '0;
        mask = '0;
        tcEn = 1'b1;
        tsEn = 1'b1;
        arst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        tick(1);
        // coin cell present from the start, so the block sits in backup
        `CHK(st, ST_BACKUP)
        `CHK(rtc.selBackup, 1'b1)
        @(posedge core_clk);
        enReq <= '1;
        host.write_rails('1, '1);
        tick(2);
        `CHK({rEn, tcOn, tsOn}, '0)
        `CHK(rRd, '0)
        `CHK(odOe, 1'b1)
        for (int s = 0; s < 3; s++) begin
            power_up(2'(s));
            if (s == 0) ready_tests();
            power_down();
        end
        wrap_up();
    end
endmodule : pmsl_power_ctrl_tb_top
